// *** mxe_data_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Banked data file: two ports, registered read data
// ==========================================================
module mxe_data_ram #(
   parameter int ADDR_W = 12,  // Byte address width
   parameter int DATA_W = 8    // Byte width
) (
   input  wire logic              i_clk,     // Core clock
   input  wire logic [ADDR_W-1:0] i_a_addr,  // Executor address
   input  wire logic              i_a_ren,   // Executor read strobe
   input  wire logic              i_a_we,    // Executor write strobe
   input  wire logic [DATA_W-1:0] i_a_wdata, // Executor write data
   output var  logic [DATA_W-1:0] o_a_rdata, // Executor read data
   input  wire logic [ADDR_W-1:0] i_b_addr,  // Software peek address
   input  wire logic              i_b_we,    // Software write strobe
   input  wire logic [DATA_W-1:0] i_b_wdata, // Software write data
   output var  logic [DATA_W-1:0] o_b_rdata  // Software read data
);
   logic [DATA_W-1:0] mem [2**ADDR_W]; // Storage, no reset by design

   // ==========================================================
   // Writes: executor listed last so it wins on the same byte
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_b_we) begin
         mem[i_b_addr] <= i_b_wdata;
      end
      if (i_a_we) begin
         mem[i_a_addr] <= i_a_wdata;
      end
   end

   // Executor read data holds when no read is asked for
   always_ff @(posedge i_clk) begin
      if (i_a_ren) begin
         o_a_rdata <= mem[i_a_addr];
      end
   end

   // Software port reads every cycle
   always_ff @(posedge i_clk) begin
      o_b_rdata <= mem[i_b_addr];
   end
endmodule
`default_nettype wire

// *** mxe_exec_top.sv ***
// Contract
// RULE1 - Two-word move: read Q2, write Q4 later
// RULE2 - Bank literal load, prefix 0x01, flags untouched
// RULE3 - Bank load one cycle, written in Q4
// RULE4 - Literal to accumulator, prefix 0x0E, flags untouched
// RULE5 - XOR accumulator with file, d picks destination
// RULE6 - Access bit 0 access bank, 1 bank register
// RULE7 - XOR sets only N and Z, one cycle
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Shared constants
// ==========================================================
package mxe_pkg;
   localparam int AXI_AW = 8;                       // Bus address width
   localparam int AXI_DW = 32;                      // Bus data width
   localparam logic [7:0] ADR_INSTR = 8'h00;        // Instruction word
   localparam logic [7:0] ADR_ACC   = 8'h04;        // Accumulator
   localparam logic [7:0] ADR_BANK  = 8'h08;        // Bank select
   localparam logic [7:0] ADR_STAT  = 8'h0C;        // Flags and state
   localparam logic [7:0] ADR_PADDR = 8'h10;        // Peek address
   localparam logic [7:0] ADR_PDATA = 8'h14;        // Peek data
   localparam logic [1:0] RESP_OKAY = 2'h0;         // Bus answer ok
   localparam logic [1:0] RESP_SLV  = 2'h2;         // Bus answer error
   localparam logic [1:0] PH_Q1 = 2'h0;             // Decode phase
   localparam logic [1:0] PH_Q2 = 2'h1;             // Read phase
   localparam logic [1:0] PH_Q3 = 2'h2;             // Process phase
   localparam logic [1:0] PH_Q4 = 2'h3;             // Write phase
   localparam logic [3:0]  OPC_MOVFF1 = 4'hC;       // First move word
   localparam logic [11:0] OPC_BANK   = 12'h010;    // Bank literal
   localparam logic [7:0]  OPC_LITACC = 8'h0E;      // Accumulator literal
   localparam logic [5:0]  OPC_XOR    = 6'h06;      // XOR with file
   localparam logic [7:0] ACC_SPLIT = 8'h80;        // Access bank split
   localparam logic [3:0] ACC_HIGH  = 4'hF;         // Upper access bank
   localparam logic [3:0] ACC_LOW   = 4'h0;         // Lower access bank
   localparam logic [7:0] ZERO8     = 8'h00;        // Reset byte
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT2} mxe_state_type;
endpackage

// ==========================================================
// Executor with AXI4-Lite register slave
// ==========================================================
module mxe_exec_top #(
   parameter int RAM_AW = 12 // Data file address width
) (
   input  wire logic                      I_SYS_CLK,     // 20 MHz core clock
   input  wire logic                      I_RST,         // Async, active high
   input  wire logic [mxe_pkg::AXI_AW-1:0] I_AWADDR,     // Write address
   input  wire logic                      I_AWVALID,     // Write address valid
   output var  logic                      O_AWREADY,     // Write address ready
   input  wire logic [mxe_pkg::AXI_DW-1:0] I_WDATA,      // Write data
   input  wire logic [3:0]                I_WSTRB,       // Byte lanes
   input  wire logic                      I_WVALID,      // Write data valid
   output var  logic                      O_WREADY,      // Write data ready
   output var  logic [1:0]                O_BRESP,       // Write answer
   output var  logic                      O_BVALID,      // Write answer valid
   input  wire logic                      I_BREADY,      // Write answer ready
   input  wire logic [mxe_pkg::AXI_AW-1:0] I_ARADDR,     // Read address
   input  wire logic                      I_ARVALID,     // Read address valid
   output var  logic                      O_ARREADY,     // Read address ready
   output var  logic [mxe_pkg::AXI_DW-1:0] O_RDATA,      // Read data
   output var  logic [1:0]                O_RRESP,       // Read answer
   output var  logic                      O_RVALID,      // Read data valid
   input  wire logic                      I_RREADY       // Read data ready
);
   import mxe_pkg::*;

   // ==========================================================
   // Declarations
   // ==========================================================
   mxe_state_type     state;         // Executor state
   logic [1:0]        phase;         // Q1..Q4 counter
   logic              second;        // Running second move word
   logic [15:0]       instr;         // Current instruction word
   logic [RAM_AW-1:0] dest;          // Move destination
   logic [7:0]        acc;           // Working register
   logic [7:0]        bank_select_reg; // Bank select
   logic              flag_n;        // Negative flag
   logic              flag_z;        // Zero flag
   logic [7:0]        result;        // Q3 result, held into Q4
   logic [RAM_AW-1:0] peek_addr;     // Software peek address
   logic [AXI_AW-1:0] aw_addr;       // Latched write address
   logic [AXI_DW-1:0] w_data;        // Latched write data
   logic [3:0]        w_strb;        // Latched byte lanes
   logic [7:0]        a_rdata;       // Executor read data
   logic [7:0]        b_rdata;       // Peek read data

   // ==========================================================
   // Decode, addressing and bus selects
   // ==========================================================
   wire run       = (state == S_RUN);
   wire is_move_file_to_file  = (instr[15:12] == OPC_MOVFF1);
   wire is_bank   = (instr[15:4] == OPC_BANK);                 // [RULE2]
   wire is_litacc = (instr[15:8] == OPC_LITACC);               // [RULE4]
   wire is_xor    = (instr[15:10] == OPC_XOR);                 // [RULE5]
   wire dst_f     = instr[9];
   wire acc_bank  = ~instr[8];
   // Access bank: low half of bank 0 plus high half of bank 15
   wire [3:0] acc_hi   = (instr[7:0] >= ACC_SPLIT) ? ACC_HIGH : ACC_LOW;
   wire [3:0] bank_hi  = acc_bank ? acc_hi : bank_select_reg[3:0]; // [RULE6]
   wire [RAM_AW-1:0] f_addr  = RAM_AW'({bank_hi, instr[7:0]});
   wire [RAM_AW-1:0] src_adr = is_move_file_to_file ? instr[RAM_AW-1:0] : f_addr;
   wire [RAM_AW-1:0] a_addr  = second ? dest : src_adr;
   // Only first-word reads; the second move word does no read
   wire a_ren = run && phase == PH_Q2 && !second && (is_move_file_to_file || is_xor); // [RULE1]
   wire a_we  = run && phase == PH_Q4 && ((second) || (is_xor && dst_f)); // [RULE1]
   wire wr_go   = !O_AWREADY && !O_WREADY && !O_BVALID;
   wire lane0   = w_strb[0];
   wire wr_ins  = wr_go && lane0 && aw_addr == ADR_INSTR;
   wire wr_acc  = wr_go && lane0 && aw_addr == ADR_ACC && state == S_IDLE;
   wire wr_bank = wr_go && lane0 && aw_addr == ADR_BANK && state == S_IDLE;
   wire wr_padr = wr_go && lane0 && aw_addr == ADR_PADDR;
   wire wr_pdat = wr_go && lane0 && aw_addr == ADR_PDATA;
   wire wr_map  = aw_addr inside {ADR_INSTR, ADR_ACC, ADR_BANK, ADR_STAT,
                                  ADR_PADDR, ADR_PDATA};
   wire rd_map  = I_ARADDR inside {ADR_INSTR, ADR_ACC, ADR_BANK, ADR_STAT,
                                   ADR_PADDR, ADR_PDATA};
   wire [AXI_DW-1:0] stat_word = AXI_DW'({state == S_WAIT2, run, flag_z, flag_n});
   wire [AXI_DW-1:0] rd_word =
      (I_ARADDR == ADR_INSTR) ? AXI_DW'(instr) :
      (I_ARADDR == ADR_ACC)   ? AXI_DW'(acc) :
      (I_ARADDR == ADR_BANK)  ? AXI_DW'(bank_select_reg) :
      (I_ARADDR == ADR_STAT)  ? stat_word :
      (I_ARADDR == ADR_PADDR) ? AXI_DW'(peek_addr) :
      (I_ARADDR == ADR_PDATA) ? AXI_DW'(b_rdata) : '0;
   // Q3 result: XOR, moved byte, or the literal from instr[7:0]
   wire [7:0] next_result = is_xor ? (acc ^ a_rdata) :         // [RULE5]
                            is_move_file_to_file ? a_rdata : instr[7:0];   // [RULE3]

   // ==========================================================
   // Data file
   // ==========================================================
   mxe_data_ram #(.ADDR_W(RAM_AW), .DATA_W(8)) u_ram (
      .i_clk     (I_SYS_CLK),
      .i_a_addr  (a_addr),
      .i_a_ren   (a_ren),
      .i_a_we    (a_we),
      .i_a_wdata (result),
      .o_a_rdata (a_rdata),
      .i_b_addr  (peek_addr),
      .i_b_we    (wr_pdat),
      .i_b_wdata (w_data[7:0]),
      .o_b_rdata (b_rdata)
   );

   // ==========================================================
   // Bus write channels: address and data taken in any order
   // ==========================================================
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_AWREADY <= 1'b1;
         O_WREADY  <= 1'b1;
         O_BVALID  <= 1'b0;
         O_BRESP   <= RESP_OKAY;
         aw_addr   <= '0;
         w_data    <= '0;
         w_strb    <= '0;
      end else begin
         if (O_AWREADY && I_AWVALID) begin
            aw_addr   <= I_AWADDR;
            O_AWREADY <= 1'b0;
         end
         if (O_WREADY && I_WVALID) begin
            w_data   <= I_WDATA;
            w_strb   <= I_WSTRB;
            O_WREADY <= 1'b0;
         end
         if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= wr_map ? RESP_OKAY : RESP_SLV;
         end else if (O_BVALID && I_BREADY) begin
            O_BVALID  <= 1'b0;
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
         end
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_ARREADY <= 1'b1;
         O_RVALID  <= 1'b0;
         O_RDATA   <= '0;
         O_RRESP   <= RESP_OKAY;
      end else if (O_ARREADY && I_ARVALID) begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b1;
         O_RDATA   <= rd_word;
         O_RRESP   <= rd_map ? RESP_OKAY : RESP_SLV;
      end else if (O_RVALID && I_RREADY) begin
         O_RVALID  <= 1'b0;
         O_ARREADY <= 1'b1;
      end
   end

   // Peek address, software only
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         peek_addr <= '0;
      end else if (wr_padr) begin
         peek_addr <= w_data[RAM_AW-1:0];
      end
   end

   // ==========================================================
   // Sequencer: one instruction cycle is four clocks
   // ==========================================================
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state  <= S_IDLE;
         phase  <= PH_Q1;
         second <= 1'b0;
         instr  <= '0;
         dest   <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               // Words arriving while running are dropped; poll busy
               if (wr_ins) begin
                  instr  <= w_data[15:0];
                  second <= 1'b0;
                  phase  <= PH_Q1;
                  state  <= S_RUN;
               end
            end
            S_WAIT2: begin
               if (wr_ins) begin
                  dest   <= w_data[RAM_AW-1:0];                // [RULE1]
                  second <= 1'b1;
                  phase  <= PH_Q1;
                  state  <= S_RUN;
               end
            end
            S_RUN: begin
               phase <= phase + 2'h1;
               if (phase == PH_Q4) begin
                  state <= (is_move_file_to_file && !second) ? S_WAIT2 : S_IDLE; // [RULE3]
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Result latched in Q3
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         result <= ZERO8;
      end else if (run && phase == PH_Q3 && !second) begin
         result <= next_result;
      end
   end

   // ==========================================================
   // Architectural registers, written in Q4 or by software idle
   // ==========================================================
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         acc             <= ZERO8;
         bank_select_reg <= ZERO8;
         flag_n          <= 1'b0;
         flag_z          <= 1'b0;
      end else if (run && phase == PH_Q4 && !second) begin
         if (is_litacc || (is_xor && !dst_f)) begin
            acc <= result;                                    // [RULE4] [RULE5]
         end
         if (is_bank) begin
            bank_select_reg <= result;                        // [RULE2] [RULE3]
         end
         if (is_xor) begin
            flag_n <= result[7];                              // [RULE7]
            flag_z <= (result == ZERO8);                      // [RULE7]
         end
      end else begin
         if (wr_acc) begin
            acc <= w_data[7:0];
         end
         if (wr_bank) begin
            bank_select_reg <= w_data[7:0];
         end
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   property p_move_src_read;
      run && is_move_file_to_file && !second && phase == PH_Q2 |-> a_ren && a_addr == instr[RAM_AW-1:0];
   endproperty
   a_move_src_read: assert property (p_move_src_read) // [RULE1]
      else $error("move source not read in Q2");
   // Second move word never touches the read port, in any phase
   property p_move_no_dummy;
      run && second |-> !a_ren;
   endproperty
   a_move_no_dummy: assert property (p_move_no_dummy) // [RULE1]
      else $error("second move word did a dummy read");
   property p_move_second_quiet;
      run && second && phase != PH_Q4 |-> !a_ren && !a_we;
   endproperty
   a_move_second_quiet: assert property (p_move_second_quiet) // [RULE1]
      else $error("second move word read or wrote early");
   property p_move_dest;
      run && second && phase == PH_Q4 |-> a_we && a_addr == dest && !a_ren;
   endproperty
   a_move_dest: assert property (p_move_dest) // [RULE1]
      else $error("move destination not written in Q4");
   property p_bank_load;
      run && is_bank && phase == PH_Q1 |-> ##4 bank_select_reg == $past(instr[7:0], 4)
         && $stable(flag_n) && $stable(flag_z) && state == S_IDLE;
   endproperty
   a_bank_load: assert property (p_bank_load) // [RULE2] [RULE3]
      else $error("bank literal load wrong");
   property p_lit_acc;
      run && is_litacc && phase == PH_Q4 |=> acc == $past(instr[7:0])
         && $stable(flag_n) && $stable(flag_z);
   endproperty
   a_lit_acc: assert property (p_lit_acc) // [RULE4]
      else $error("accumulator literal load wrong");
   property p_xor_val;
      run && is_xor && phase == PH_Q3 |=> result == ($past(acc) ^ $past(a_rdata));
   endproperty
   a_xor_val: assert property (p_xor_val) // [RULE5]
      else $error("xor result wrong");
   property p_xor_dest;
      run && is_xor && phase == PH_Q4 |-> (a_we == dst_f) ##1 (dst_f || acc == $past(result));
   endproperty
   a_xor_dest: assert property (p_xor_dest) // [RULE5]
      else $error("xor destination wrong");
   property p_access;
      run && is_xor |-> a_addr[RAM_AW-1:8] == (instr[8] ? bank_select_reg[3:0] :
         (instr[7] ? ACC_HIGH : ACC_LOW));
   endproperty
   a_access: assert property (p_access) // [RULE6]
      else $error("bank selection wrong");
   property p_xor_flags;
      run && is_xor && phase == PH_Q4 |=> flag_z == ($past(result) == ZERO8)
         && flag_n == $past(result[7]) && state == S_IDLE;
   endproperty
   a_xor_flags: assert property (p_xor_flags) // [RULE7]
      else $error("xor flags wrong");

   c_move_done: cover property (run && second && a_we);
   c_xor_file: cover property (run && is_xor && dst_f && a_we);
   c_bank_load: cover property (run && is_bank && phase == PH_Q4);
endmodule
`default_nettype wire

// *** mxe_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus master standing in for the instruction fetch side
// ==========================================================
module mxe_host_model (
   input  wire logic                       i_clk,     // Core clock
   output var  logic [mxe_pkg::AXI_AW-1:0] o_awaddr,  // Write address
   output var  logic                       o_awvalid, // Write address valid
   input  wire logic                       i_awready, // Write address ready
   output var  logic [mxe_pkg::AXI_DW-1:0] o_wdata,   // Write data
   output var  logic [3:0]                 o_wstrb,   // Byte lanes
   output var  logic                       o_wvalid,  // Write data valid
   input  wire logic                       i_wready,  // Write data ready
   input  wire logic [1:0]                 i_bresp,   // Write answer
   input  wire logic                       i_bvalid,  // Write answer valid
   output var  logic                       o_bready,  // Write answer ready
   output var  logic [mxe_pkg::AXI_AW-1:0] o_araddr,  // Read address
   output var  logic                       o_arvalid, // Read address valid
   input  wire logic                       i_arready, // Read address ready
   input  wire logic [mxe_pkg::AXI_DW-1:0] i_rdata,   // Read data
   input  wire logic [1:0]                 i_rresp,   // Read answer
   input  wire logic                       i_rvalid,  // Read data valid
   output var  logic                       o_rready   // Read data ready
);
   import mxe_pkg::*;
   // Idle bus from time zero
   initial begin
      o_awaddr = '0; o_awvalid = 1'b0; o_wdata = '0; o_wstrb = 4'h0;
      o_wvalid = 1'b0; o_bready = 1'b0; o_araddr = '0; o_arvalid = 1'b0; o_rready = 1'b0;
   end
   // One write; starts on a fresh edge so no signal is driven twice in one step
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                     output logic [1:0] r);
      logic aw_on;
      logic w_on;
      @(posedge i_clk);
      o_awaddr <= a; o_awvalid <= 1'b1; o_wdata <= d; o_wstrb <= 4'hF;
      o_wvalid <= 1'b1; o_bready <= 1'b1;
      aw_on = 1'b1; w_on = 1'b1; r = 2'h3;
      for (int n = 0; n < 100; n++) begin
         @(posedge i_clk);
         // Each channel drops only at its own handshake edge
         if (aw_on && i_awready === 1'b1) begin o_awvalid <= 1'b0; aw_on = 1'b0; end
         if (w_on && i_wready === 1'b1) begin o_wvalid <= 1'b0; w_on = 1'b0; end
         if (i_bvalid === 1'b1) begin r = i_bresp; o_bready <= 1'b0; break; end
      end
   endtask
   // One read; answer taken at the edge where rvalid is seen
   task automatic rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                     output logic [1:0] r);
      logic ar_on;
      @(posedge i_clk);
      o_araddr <= a; o_arvalid <= 1'b1; o_rready <= 1'b1;
      ar_on = 1'b1; d = 'x; r = 2'h3;
      for (int n = 0; n < 100; n++) begin
         @(posedge i_clk);
         if (ar_on && i_arready === 1'b1) begin o_arvalid <= 1'b0; ar_on = 1'b0; end
         if (i_rvalid === 1'b1) begin d = i_rdata; r = i_rresp; o_rready <= 1'b0; break; end
      end
   endtask
endmodule
`default_nettype wire

// *** move_and_xor_instr_exec_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
// ==========================================================
// Self-checking bench for the executor
// ==========================================================
module move_and_xor_instr_exec_bench;
   import mxe_pkg::*;
   logic clk = 1'b0;          // Core clock
   logic rst = 1'b1;          // Reset, high at start
   int error_cnt = 0;         // Mismatches
   int check_count = 0;       // Comparisons
   wire logic [7:0]  awaddr, araddr;
   wire logic [31:0] wdata, rdata;
   wire logic [3:0]  wstrb;
   wire logic [1:0]  bresp, rresp;
   wire logic awvalid, awready, wvalid, wready, bvalid, bready;
   wire logic arvalid, arready, rvalid, rready;
   logic [1:0]  r;            // Last bus answer
   logic [31:0] d;            // Last read data
   mxe_exec_top uut (.I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
   mxe_host_model host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
      .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
      .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
   // ==========================================================
   // Helpers
   // ==========================================================
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic summarize();
      if (error_cnt == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Read one register and compare
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      host.rd(a, d, r);
      `CHK(d, e)
      `CHK(r, RESP_OKAY)
   endtask
   // Poll status until busy clears; bounded so a stuck core shows up
   task automatic wait_idle();
      d = 32'h4;
      for (int n = 0; n < 20 && d[2] !== 1'b0; n++) host.rd(ADR_STAT, d, r);
      `CHK(d[2], 1'b0)
   endtask
   task automatic exec(input logic [15:0] ins);
      host.wr(ADR_INSTR, {16'h0000, ins}, r);
      `CHK(r, RESP_OKAY)
      wait_idle();
   endtask
   // Data file byte access through the peek window
   task automatic poke(input logic [11:0] a, input logic [7:0] b);
      host.wr(ADR_PADDR, {20'h0, a}, r);
      host.wr(ADR_PDATA, {24'h0, b}, r);
   endtask
   task automatic peek(input logic [11:0] a, input logic [7:0] e);
      host.wr(ADR_PADDR, {20'h0, a}, r);
      rdc(ADR_PDATA, {24'h0, e});
   endtask
   // ==========================================================
   // Watchdog: the whole sequence needs well under a thousand cycles
   // ==========================================================
   initial begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   // ==========================================================
   // Test sequence
   // ==========================================================
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdc(ADR_ACC, 32'h0);
      rdc(ADR_BANK, 32'h0);
      rdc(ADR_STAT, 32'h0);
      poke(12'h010, 8'hAF);
      poke(12'h510, 8'h3C);
      poke(12'hF90, 8'h1A);
      poke(12'h011, 8'h01);
      // Bank load: busy while it runs, then bank holds the literal
      host.wr(ADR_INSTR, 32'h0105, r);
      host.rd(ADR_STAT, d, r);
      `CHK(d[2], 1'b1)
      wait_idle();
      rdc(ADR_BANK, 32'h5);
      exec(16'h0EB5);
      rdc(ADR_ACC, 32'hB5);
      // XOR into accumulator, lower access bank
      exec(16'h1810);
      rdc(ADR_ACC, 32'h1A);
      rdc(ADR_STAT, 32'h0);
      // XOR back to file through the bank register
      exec(16'h1B10);
      rdc(ADR_ACC, 32'h1A);
      peek(12'h510, 8'h26);
      peek(12'h010, 8'hAF);
      // Upper access bank, result zero
      exec(16'h1890);
      rdc(ADR_ACC, 32'h0);
      rdc(ADR_STAT, 32'h2);
      exec(16'h0E80);
      rdc(ADR_STAT, 32'h2);
      rdc(ADR_ACC, 32'h80);
      exec(16'h1811);
      rdc(ADR_ACC, 32'h81);
      rdc(ADR_STAT, 32'h1);
      exec(16'h0107);
      rdc(ADR_BANK, 32'h7);
      rdc(ADR_STAT, 32'h1);
      // Two-word move: nothing written until the second word
      poke(12'h123, 8'h33);
      poke(12'h456, 8'h11);
      exec(16'hC123);
      rdc(ADR_STAT, 32'h9);
      peek(12'h456, 8'h11);
      exec(16'hF456);
      peek(12'h456, 8'h33);
      peek(12'h123, 8'h33);
      rdc(ADR_STAT, 32'h1);
      // Unmapped address answers with an error and reads zero
      host.wr(8'h40, 32'h5A, r);
      `CHK(r, RESP_SLV)
      host.rd(8'h40, d, r);
      `CHK(r, RESP_SLV)
      `CHK(d, 32'h0)
      summarize();
   end
endmodule
`default_nettype wire
